// file: include/bcp_pkg.sv
// constants shared by the commutation and protection core
// Summary of operation
// R1: supply low lockout turns every switch off
// R2: quadrant select low two-quad, high four-quad
// R3: tach pulses fixed width, rate follows speed
// R4: one tach pulse per any sensor edge; an edge during a running pulse retriggers and lengthens that pulse instead
// R5: brake: low sides off, high sides on
// R6: brake high side gated only by listed conditions
// R7: freewheel high disables all outputs
// R8: run enable low disables all outputs
// R9: direction output decoded from sensor sequence
// R10: direction output matches command while motoring
// R11: command high forward, low reverse
// R12: direction latch transparent below speed threshold
// R13: reversal above speed forces freewheel until slow
// R14: system should use latch in two-quad
// R15: sensor codes 000 and 111 are invalid
// R16: system inverts 60 degree sensors externally
// R17: sensor inputs filtered against glitches
// R18: over-current ends high side until next period
// R19: pwm comparator gates duty each period
// R20: two-quad modulates high side, low side on
// R21: four-quad modulates both active switches
// R22: one source, one sink, third off
package bcp_pkg;
    localparam int CLK_PERIOD_NS  = 4;
    localparam int TACH_ON_NS     = 120000;
    localparam int TACH_ON_CYC    = TACH_ON_NS / CLK_PERIOD_NS;
    localparam int PWM_PERIOD_NS  = 50000;
    localparam int PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_PERIOD_NS;
    localparam int HALL_FILT_NS   = 1000;
    localparam int HALL_FILT_CYC  = HALL_FILT_NS / CLK_PERIOD_NS;

    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] TACHW_OFS  = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;

    localparam int CTRL_RUN_BIT        = 0;
    localparam logic CTRL_RUN_RST      = 1'b1;
    localparam int TACHW_WIDTH         = 16;

    localparam int ST_OC_BIT     = 0;
    localparam int ST_LOCK_BIT   = 1;
    localparam int ST_COAST_BIT  = 2;
    localparam int ST_LDIR_BIT   = 3;
    localparam int ST_DSENSE_BIT = 4;
    localparam int ST_HALL_LSB   = 5;
    localparam int ST_LS_LSB     = 8;
    localparam int ST_HS_LSB     = 11;
endpackage

// file: hw/bcp_sync.sv
// three-flop pin synchroniser with an optional stability filter
`timescale 1ns/10ps
module bcp_sync
    import bcp_pkg::*;
#(
    parameter int W    = 1,
    parameter int FILT = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // pins and filtered result
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] sync_o
);
    localparam int CW = $clog2(FILT + 1);
    logic [W-1:0]  s1_reg, s2_reg, s3_reg;
    logic [CW-1:0] cnt_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change must hold FILT+1 agreeing samples before it is believed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            sync_o  <= RST_VAL;
        end else if (s2_reg != s3_reg || s3_reg == sync_o) begin
            cnt_reg <= '0;
        end else if (cnt_reg >= CW'(FILT - 1)) begin
            cnt_reg <= '0;
            sync_o  <= s3_reg; // R17
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule // bcp_sync

// file: hw/bcp_pulse.sv
// retriggerable one-shot of programmable width for the tachometer
`timescale 1ns/10ps
module bcp_pulse
    import bcp_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // trigger, width and pulse
    input  wire logic                   trig_i,
    input  wire logic [TACHW_WIDTH-1:0] width_i,
    output logic                        pulse_o
);
    logic [TACHW_WIDTH-1:0] cnt_reg;

    // a zero width still gives a one-cycle pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            pulse_o <= 1'b0;
        end else if (trig_i) begin
            cnt_reg <= (width_i == '0) ? TACHW_WIDTH'(1) : width_i; // R3
            pulse_o <= 1'b1;
        end else if (cnt_reg > TACHW_WIDTH'(1)) begin
            cnt_reg <= cnt_reg - 1'b1;
        end else begin
            cnt_reg <= '0;
            pulse_o <= 1'b0;
        end
    end
endmodule // bcp_pulse

// file: hw/bcp_core.sv
// commutation, braking, direction latch and protection gating core
`timescale 1ns/10ps
module bcp_core
    import bcp_pkg::*;
#(
    parameter int TACH_CYC  = TACH_ON_CYC,
    parameter int PWM_CYC   = PWM_PERIOD_CYC,
    parameter int HALL_FILT = HALL_FILT_CYC
) (
    // clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_I,
    // rotor position sensors, bit 2 = a
    input  wire logic [2:0]  ROTOR_POS_I,
    // control pins
    input  wire logic        QUADRANT_SELECT_I,
    input  wire logic        BRAKE_I,
    input  wire logic        FREEWHEEL_ALL_I,
    input  wire logic        RUN_ENABLE_I,
    input  wire logic        ROTATION_SENSE_CMD_I,
    // comparator results
    input  wire logic        SUPPLY_LOW_LOCKOUT_I,
    input  wire logic        PWM_CMP_I,
    input  wire logic        OVER_CURRENT_I,
    input  wire logic        ROTOR_RATE_ABOVE_I,
    // bridge gate commands, bit 2 = phase a
    output logic [2:0]       PHASE_HS_ON_O,
    output logic [2:0]       PHASE_LS_ON_O,
    // status pins
    output logic             SPEED_PULSE_O,
    output logic             DECODED_ROTATION_SENSE_O,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic [31:0]      PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O
);
    localparam int PW = $clog2(PWM_CYC + 1);

    // forward sequence of valid sensor codes, a b c
    function automatic logic [2:0] hall_next(input logic [2:0] c);
        unique case (c)
            3'b001:  hall_next = 3'b011;
            3'b011:  hall_next = 3'b010;
            3'b010:  hall_next = 3'b110;
            3'b110:  hall_next = 3'b100;
            3'b100:  hall_next = 3'b101;
            3'b101:  hall_next = 3'b001;
            default: hall_next = 3'b000;
        endcase
    endfunction

    function automatic logic hall_valid(input logic [2:0] c);
        hall_valid = (c != 3'b000) && (c != 3'b111); // R15
    endfunction

    // returns {source, sink}, each bit 2 = phase a
    function automatic logic [5:0] commutate(input logic [2:0] c,
                                             input logic fwd);
        logic [5:0] r;
        r = 6'b000_000;
        unique case (c)
            3'b001:  r = 6'b001_010;
            3'b011:  r = 6'b001_100;
            3'b010:  r = 6'b010_100;
            3'b110:  r = 6'b010_001;
            3'b100:  r = 6'b100_001;
            3'b101:  r = 6'b100_010;
            default: r = 6'b000_000; // R22
        endcase
        // reverse swaps source and sink on every step
        commutate = fwd ? r : {r[2:0], r[5:3]}; // R11
    endfunction

    logic [2:0] hall_s;
    logic [7:0] ctl_s;
    logic quad_s, brake_s, free_s, run_pin_s, dir_cmd_s;
    logic lock_s, pwm_s, oc_s, rate_s;

    bcp_sync #(.W(3), .FILT(HALL_FILT), .RST_VAL(3'b111)) u_hall_sync (
        .clk_i  (CLK_SYS_I),
        .rst_i  (RST_I),
        .pin_i  (ROTOR_POS_I),
        .sync_o (hall_s)
    );

    // lockout resets high so the bridge stays off until proven safe
    bcp_sync #(.W(8), .FILT(1), .RST_VAL(8'b0001_0100)) u_ctl_sync (
        .clk_i  (CLK_SYS_I),
        .rst_i  (RST_I),
        .pin_i  ({QUADRANT_SELECT_I, BRAKE_I, FREEWHEEL_ALL_I,
                  RUN_ENABLE_I, ROTATION_SENSE_CMD_I,
                  SUPPLY_LOW_LOCKOUT_I, PWM_CMP_I, OVER_CURRENT_I}),
        .sync_o (ctl_s)
    );
    assign {quad_s, brake_s, free_s, run_pin_s, dir_cmd_s,
            lock_s, pwm_s, oc_s} = ctl_s;

    // speed comparator kept apart so a stuck value is easy to see
    bcp_sync #(.W(1), .FILT(1), .RST_VAL(1'b0)) u_rate_sync (
        .clk_i  (CLK_SYS_I),
        .rst_i  (RST_I),
        .pin_i  (ROTOR_RATE_ABOVE_I),
        .sync_o (rate_s)
    );

    // ---------------- registers -----------------
    logic                   run_sw_reg;
    logic [TACHW_WIDTH-1:0] tach_w_reg;
    logic                   acc_ok;
    logic                   wr_en;
    logic [31:0]            status;

    assign acc_ok = (PADDR_I == CTRL_OFS) || (PADDR_I == TACHW_OFS)
                 || (PADDR_I == STATUS_OFS);
    assign wr_en  = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
        end else if (PSEL_I && PENABLE_I && !PREADY_O) begin
            PREADY_O  <= 1'b1;
            PSLVERR_O <= !acc_ok;
            unique case (PADDR_I)
                CTRL_OFS:   PRDATA_O <= {31'h0000_0000, run_sw_reg};
                TACHW_OFS:  PRDATA_O <= {16'h0000, tach_w_reg};
                STATUS_OFS: PRDATA_O <= status;
                default:    PRDATA_O <= 32'h0000_0000;
            endcase
        end else begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            run_sw_reg <= CTRL_RUN_RST;
            tach_w_reg <= TACHW_WIDTH'(TACH_CYC);
        end else if (wr_en && PADDR_I == CTRL_OFS) begin
            run_sw_reg <= PWDATA_I[CTRL_RUN_BIT];
        end else if (wr_en && PADDR_I == TACHW_OFS) begin
            tach_w_reg <= PWDATA_I[TACHW_WIDTH-1:0];
        end
    end

    // ---------------- tachometer and rotation sense -----------------
    logic [2:0] hall_d_reg;
    logic       hall_edge;
    logic       dsense_reg;

    assign hall_edge = (hall_s != hall_d_reg);

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            hall_d_reg <= 3'b111;
        end else begin
            hall_d_reg <= hall_s;
        end
    end

    bcp_pulse u_tach (
        .clk_i   (CLK_SYS_I),
        .rst_i   (RST_I),
        .trig_i  (hall_edge), // R4
        .width_i (tach_w_reg),
        .pulse_o (SPEED_PULSE_O)
    );

    // only steps between two valid neighbours count as motion
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            dsense_reg <= 1'b1;
        end else if (hall_edge && hall_valid(hall_d_reg)) begin
            if (hall_s == hall_next(hall_d_reg)) begin
                dsense_reg <= 1'b1; // R9
            end else if (hall_d_reg == hall_next(hall_s)) begin
                dsense_reg <= 1'b0; // R9
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            DECODED_ROTATION_SENSE_O <= 1'b1;
        end else begin
            DECODED_ROTATION_SENSE_O <= dsense_reg; // R10
        end
    end

    // ---------------- direction latch -----------------
    logic ldir_reg;
    logic coast_reg;

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            ldir_reg  <= 1'b1;
            coast_reg <= 1'b0;
        end else if (!rate_s) begin
            ldir_reg  <= dir_cmd_s; // R12
            coast_reg <= 1'b0;
        end else if (dir_cmd_s != ldir_reg) begin
            coast_reg <= 1'b1; // R13
        end
    end

    // ---------------- pwm period and current limit -----------------
    logic [PW-1:0] pwm_cnt_reg;
    logic          period_start;
    logic          oc_reg;

    assign period_start = (pwm_cnt_reg == '0);

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || pwm_cnt_reg >= PW'(PWM_CYC - 1)) begin
            pwm_cnt_reg <= '0;
        end else begin
            pwm_cnt_reg <= pwm_cnt_reg + 1'b1;
        end
    end

    // a trip holds until the next period; a trip at the start wins
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            oc_reg <= 1'b0;
        end else if (oc_s) begin
            oc_reg <= 1'b1; // R18
        end else if (period_start) begin
            oc_reg <= 1'b0;
        end
    end

    // ---------------- gate drive -----------------
    logic       enabled;
    logic       mod_on;
    logic [5:0] step;
    logic [2:0] hs_next, ls_next;

    assign enabled = !lock_s && !free_s && !coast_reg
                  && run_pin_s && run_sw_reg; // R7 R8 R13
    assign mod_on  = pwm_s && !oc_reg && !oc_s; // R19 R18
    assign step    = commutate(hall_s, ldir_reg);

    always_comb begin
        hs_next = 3'b000;
        ls_next = 3'b000;
        if (lock_s || !enabled) begin
            hs_next = 3'b000; // R1
            ls_next = 3'b000;
        end else if (brake_s) begin
            ls_next = 3'b000; // R5
            hs_next = pwm_s ? 3'b111 : 3'b000; // R6
        end else if (!quad_s) begin
            hs_next = mod_on ? step[5:3] : 3'b000; // R20 R2
            ls_next = step[2:0];
        end else begin
            hs_next = mod_on ? step[5:3] : 3'b000; // R21 R2
            ls_next = mod_on ? step[2:0] : 3'b000;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            PHASE_HS_ON_O <= 3'b000;
            PHASE_LS_ON_O <= 3'b000;
        end else begin
            PHASE_HS_ON_O <= hs_next;
            PHASE_LS_ON_O <= ls_next;
        end
    end

    always_comb begin
        status = 32'h0000_0000;
        status[ST_OC_BIT]     = oc_reg;
        status[ST_LOCK_BIT]   = lock_s;
        status[ST_COAST_BIT]  = coast_reg;
        status[ST_LDIR_BIT]   = ldir_reg;
        status[ST_DSENSE_BIT] = dsense_reg;
        status[ST_HALL_LSB +: 3] = hall_s;
        status[ST_LS_LSB +: 3]   = PHASE_LS_ON_O;
        status[ST_HS_LSB +: 3]   = PHASE_HS_ON_O;
    end

    // ---------------- checks -----------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    property p_lockout;
        lock_s |=> (PHASE_HS_ON_O == 3'b000) && (PHASE_LS_ON_O == 3'b000);
    endproperty
    a_lockout: assert property (p_lockout) // R1
        else $error("outputs on during lockout");

    property p_brake_ls;
        brake_s && enabled |=> PHASE_LS_ON_O == 3'b000;
    endproperty
    a_brake_ls: assert property (p_brake_ls) // R5
        else $error("low side on during brake");

    property p_brake_hs;
        brake_s && enabled && pwm_s && oc_s |=> PHASE_HS_ON_O == 3'b111;
    endproperty
    a_brake_hs: assert property (p_brake_hs) // R6
        else $error("brake high side wrongly inhibited");

    property p_free_run;
        free_s || !run_pin_s |=> (PHASE_HS_ON_O | PHASE_LS_ON_O) == 3'b000;
    endproperty
    a_free_run: assert property (p_free_run) // R7
        else $error("outputs on while freewheel or stopped");

    property p_tach;
        hall_edge |=> SPEED_PULSE_O;
    endproperty
    a_tach: assert property (p_tach) // R4
        else $error("no speed pulse after sensor edge");

    property p_dir_latch;
        !rate_s |=> ldir_reg == $past(dir_cmd_s) && !coast_reg;
    endproperty
    a_dir_latch: assert property (p_dir_latch) // R12
        else $error("direction latch not transparent");

    property p_coast_hold;
        coast_reg && rate_s |=> coast_reg;
    endproperty
    a_coast_hold: assert property (p_coast_hold) // R13
        else $error("forced freewheel released early");

    property p_oc;
        oc_reg && !brake_s |=> PHASE_HS_ON_O == 3'b000;
    endproperty
    a_oc: assert property (p_oc) // R18
        else $error("high side on after over-current");

    property p_one_pair;
        enabled && !brake_s && hall_valid(hall_s) && !quad_s
            |=> $onehot(PHASE_LS_ON_O) && $onehot0(PHASE_HS_ON_O)
                && (PHASE_LS_ON_O & PHASE_HS_ON_O) == 3'b000;
    endproperty
    a_one_pair: assert property (p_one_pair) // R22
        else $error("commutation leg pair wrong");

    property p_invalid;
        !hall_valid(hall_s) && !brake_s
            |=> (PHASE_HS_ON_O | PHASE_LS_ON_O) == 3'b000;
    endproperty
    a_invalid: assert property (p_invalid) // R15
        else $error("outputs on with invalid sensor code");

    c_brake:   cover property (brake_s && enabled && pwm_s);
    c_coast:   cover property (rate_s ##1 coast_reg ##[1:100] !coast_reg);
    c_oc:      cover property (oc_s ##1 period_start);
    c_reverse: cover property (hall_edge && hall_valid(hall_s)
                                && hall_d_reg == hall_next(hall_s));
endmodule // bcp_core

// file: verification/bcp_pads_model.sv
// behavioural hall sensors and control pads in front of the core
`timescale 1ns/10ps
module bcp_pads_model (
    // clock
    input  wire logic       clk_i,
    // sensor stepping and pad drive
    input  wire logic       step_i,
    input  wire logic       fwd_i,
    input  wire logic       hall_drv_i,
    input  wire logic       ctl_drv_i,
    input  wire logic       run_val_i,
    input  wire logic       coast_val_i,
    // pad levels seen by the core
    output logic      [2:0] pos_o,
    output logic            run_o,
    output logic            coast_o
);
    // 120 degree order a,b,c; never all high nor all low
    localparam logic [2:0] CODE [6] = '{3'h1, 3'h3, 3'h2,
                                        3'h6, 3'h4, 3'h5};
    int idx_reg = 0;

    always_ff @(posedge clk_i) begin
        if (step_i) begin
            idx_reg <= fwd_i ? (idx_reg + 1) % 6 : (idx_reg + 5) % 6;
        end
    end

    // an undriven pad settles at its internal pull level
    assign pos_o   = hall_drv_i ? CODE[idx_reg] : 3'h7;
    assign run_o   = ctl_drv_i ? run_val_i : 1'h1;
    assign coast_o = ctl_drv_i ? coast_val_i : 1'h0;
endmodule // bcp_pads_model

// file: verification/bcp_core_test.sv
// self-checking bench for the commutation and protection core
`timescale 1ns/10ps
module bcp_core_test;
    import bcp_pkg::*;
    localparam int TACH   = 20;
    localparam int PWM    = 64;
    localparam int SETTLE = 12;
    localparam int LIMIT  = 20000;
    localparam logic [2:0] HS_F [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
    localparam logic [2:0] LS_F [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
    logic        clk = 1'h0, rst = 1'h1, step_q = 1'h0, fwd = 1'h1;
    logic        hall_drv = 1'h1, ctl_drv = 1'h1, run_v = 1'h1;
    logic        coast_v = 1'h0, quad = 1'h0, brake = 1'h0, dir_cmd = 1'h1;
    logic        lockout = 1'h0, pwm = 1'h1, oc = 1'h0, rate = 1'h0;
    logic        psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [2:0]  pos, hs, ls;
    logic        run, coast, pready, pslverr, tach, dsense;
    int          failures = 0, checked = 0, cycles = 0, idx = 0;

    always #2 clk = ~clk;

    bcp_pads_model u_bcp_pads_model (
        .clk_i(clk), .step_i(step_q), .fwd_i(fwd), .hall_drv_i(hall_drv),
        .ctl_drv_i(ctl_drv), .run_val_i(run_v), .coast_val_i(coast_v),
        .pos_o(pos), .run_o(run), .coast_o(coast)
    );

    bcp_core #(.TACH_CYC(TACH), .PWM_CYC(PWM), .HALL_FILT(2)) u_bcp_core (
        .CLK_SYS_I(clk), .RST_I(rst), .ROTOR_POS_I(pos),
        .QUADRANT_SELECT_I(quad), .BRAKE_I(brake), .FREEWHEEL_ALL_I(coast),
        .RUN_ENABLE_I(run), .ROTATION_SENSE_CMD_I(dir_cmd),
        .SUPPLY_LOW_LOCKOUT_I(lockout), .PWM_CMP_I(pwm),
        .OVER_CURRENT_I(oc), .ROTOR_RATE_ABOVE_I(rate),
        .PHASE_HS_ON_O(hs), .PHASE_LS_ON_O(ls), .SPEED_PULSE_O(tach),
        .DECODED_ROTATION_SENSE_O(dsense), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr)
    );

    task automatic finish_test;
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            finish_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask

    task automatic settle;
        repeat (SETTLE) @(posedge clk);
    endtask

    task automatic step(input logic f);
        @(posedge clk);
        fwd <= f;
        step_q <= 1'h1;
        @(posedge clk);
        step_q <= 1'h0;
        idx = f ? (idx + 1) % 6 : (idx + 5) % 6;
    endtask

    task automatic gates(input logic [2:0] ehs, input logic [2:0] els);
        chk("phase_hs_on", ehs, hs);
        chk("phase_ls_on", els, ls);
    endtask

    // k picks one inhibit source: lockout, pwm off, coast, run low
    task automatic inhibit(input int k, input logic v);
        case (k)
            0: lockout <= v;
            1: pwm <= ~v;
            2: coast_v <= v;
            default: run_v <= ~v;
        endcase
    endtask

    // tach width in cycles, counted from the first high sample
    task automatic tach_width(output int n);
        int k;
        n = 0;
        k = 0;
        while (tach !== 1'h1 && k < 40) begin
            @(posedge clk);
            k++;
        end
        while (tach === 1'h1 && n < 100) begin
            @(posedge clk);
            n++;
        end
    endtask

    initial begin
        int          n;
        logic [31:0] rd;
        logic        err;
        logic [2:0]  el;
        repeat (16) @(posedge clk);
        chk("dsense_reset", 32'h0000_0001, dsense);
        rst <= 1'h0;
        apb(1'h0, CTRL_OFS, 32'h0000_0000, rd, err);
        chk("ctrl", 32'h0000_0001, rd);
        apb(1'h0, TACHW_OFS, 32'h0000_0000, rd, err);
        chk("tachw", TACH, rd);
        apb(1'h0, 8'h0C, 32'h0000_0000, rd, err);
        chk("unmapped_err", 32'h0000_0001, err);
        chk("unmapped_rd", 32'h0000_0000, rd);
        apb(1'h1, STATUS_OFS, 32'hFFFF_FFFF, rd, err);
        apb(1'h0, STATUS_OFS, 32'h0000_0000, rd, err);
        chk("status_hall", 3'h1, rd[ST_HALL_LSB +: 3]);
        settle();
        for (int i = 0; i < 6; i++) begin
            gates(HS_F[idx], LS_F[idx]);
            step(1'h1);
            settle();
        end
        chk("dsense_fwd", 32'h0000_0001, dsense);
        dir_cmd <= 1'h0;
        settle();
        for (int i = 0; i < 6; i++) begin
            gates(LS_F[idx], HS_F[idx]);
            step(1'h0);
            settle();
        end
        chk("dsense_rev", 32'h0000_0000, dsense);
        pwm <= 1'h0;
        settle();
        gates(3'h0, HS_F[idx]);
        quad <= 1'h1;
        settle();
        gates(3'h0, 3'h0);
        pwm <= 1'h1;
        settle();
        gates(LS_F[idx], HS_F[idx]);
        quad <= 1'h0;
        oc <= 1'h1;
        settle();
        gates(3'h0, HS_F[idx]);
        oc <= 1'h0;
        repeat (PWM + SETTLE) @(posedge clk);
        gates(LS_F[idx], HS_F[idx]);
        oc <= 1'h1;
        brake <= 1'h1;
        settle();
        gates(3'h7, 3'h0);
        oc <= 1'h0;
        for (int b = 1; b >= 0; b--) begin
            brake <= b[0];
            el = b ? 3'h0 : HS_F[idx];
            for (int k = 0; k < 4; k++) begin
                inhibit(k, 1'h1);
                settle();
                gates(3'h0, (k == 1 && b == 0) ? el : 3'h0);
                inhibit(k, 1'h0);
                settle();
                gates(b ? 3'h7 : LS_F[idx], el);
            end
        end
        run_v <= 1'h0;
        coast_v <= 1'h1;
        ctl_drv <= 1'h0;
        settle();
        gates(LS_F[idx], HS_F[idx]);
        apb(1'h1, CTRL_OFS, 32'h0000_0000, rd, err);
        apb(1'h0, CTRL_OFS, 32'h0000_0000, rd, err);
        chk("ctrl_off", 32'h0000_0000, rd);
        settle();
        gates(3'h0, 3'h0);
        apb(1'h1, CTRL_OFS, 32'h0000_0001, rd, err);
        ctl_drv <= 1'h1;
        run_v <= 1'h1;
        coast_v <= 1'h0;
        hall_drv <= 1'h0;
        settle();
        gates(3'h0, 3'h0);
        hall_drv <= 1'h1;
        repeat (3 * TACH) @(posedge clk);
        step(1'h0);
        tach_width(n);
        chk("tach_width", TACH, n);
        chk("dsense_rev2", 32'h0000_0000, dsense);
        apb(1'h1, TACHW_OFS, 32'h0000_000A, rd, err);
        step(1'h1);
        tach_width(n);
        chk("tach_width_short", 32'h0000_000A, n);
        chk("dsense_fwd2", 32'h0000_0001, dsense);
        rate <= 1'h1;
        dir_cmd <= 1'h1;
        repeat (4 * SETTLE) @(posedge clk);
        gates(3'h0, 3'h0);
        apb(1'h0, STATUS_OFS, 32'h0000_0000, rd, err);
        chk("status_coast", 32'h0000_0001, rd[ST_COAST_BIT]);
        rate <= 1'h0;
        settle();
        gates(HS_F[idx], LS_F[idx]);
        finish_test();
    end
endmodule // bcp_core_test
